// [include/pci_pm_pkg.sv]
// Constants and types shared by the power-management capability registers.
package pci_pm_pkg;
    localparam logic [7:0] CAP_PTR_ADDR = 8'h34;
    localparam logic [7:0] CAP_BASE_DEFAULT = 8'h50;
    localparam logic [7:0] CAPABILITY_IDENTIFIER_VALUE = 8'h01;
    localparam logic [7:0] NEXT_PTR_OPEN = 8'h00;
    localparam logic [7:0] NEXT_PTR_ENH = 8'he4;
    localparam logic [7:0] OFS_ID = 8'h00;
    localparam logic [7:0] OFS_NEXT = 8'h01;
    localparam logic [7:0] OFS_PMC = 8'h02;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_BRIDGE = 8'h06;
    localparam logic [7:0] OFS_DATA = 8'h07;
    localparam int WAKE_LSB = 11;
    localparam int D2_BIT = 10;
    localparam int D1_BIT = 9;
    localparam int AUX_LSB = 6;
    localparam int DSI_BIT = 5;
    localparam int RSVD_BIT = 4;
    localparam int PMI_BIT = 3;
    localparam int VER_LSB = 0;
    localparam logic [4:0] WAKE_OPEN = 5'h1a;
    localparam logic [4:0] WAKE_ENH = 5'h1f;
    localparam logic [2:0] AUX_DEFAULT = 3'h2;
    localparam logic [2:0] AUX_NONE = 3'h0;
    localparam logic [2:0] VER_VALUE = 3'h2;
    localparam logic [15:0] PMC_ZERO = 16'h0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Bit n of the code matches wake-support bit n of the capabilities word.
    typedef enum logic [4:0] {
        PS_D0 = 5'h01,
        PS_D1 = 5'h02,
        PS_D2 = 5'h04,
        PS_D3HOT = 5'h08,
        PS_D3COLD = 5'h10
    } power_state_t;
endpackage

// [hw/wake_gate.sv]
// Gates the function's wake request by the wake support of its present power state.
`timescale 1ns/1ns
`default_nettype none
module wake_gate (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire pci_pm_pkg::power_state_t power_state,
    input wire logic [4:0] wake_support_per_state,
    input wire logic wake_request,
    output logic wake_assert
);
    import pci_pm_pkg::*;

    logic wake_q;
    logic wake_d;
    wire logic state_allows = |(power_state & wake_support_per_state);

    assign wake_d = wake_request & state_allows;
    assign wake_assert = wake_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
        end
    end

    wake_allowed_a: assert property (@(posedge mclk) disable iff (sys_rst)
        wake_assert |-> $past(state_allows))
        else $error("Wake asserted from a state without wake support.");

    wake_follows_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (wake_request && state_allows) |=> wake_assert)
        else $error("Allowed wake request was dropped.");

    wake_blocked_c: cover property (@(posedge mclk) disable iff (sys_rst)
        wake_request && !state_allows);
endmodule
`default_nettype wire

// [hw/pci_power_capability_regs.sv]
// Read-only power-management capability structure in a host function's configuration space.
//
// Behaviour
// - Pointer at 34h gives the base; fields sit at fixed offsets from it.
// - Identifier byte is read-only and reads 01h.
// - Only one capability item per function carries identifier 01h.
// - Next-pointer byte is read-only, offset of next item, 00h if last.
// - Next pointer resets to 00h for open host, E4h for enhanced host.
// - Capabilities word read-only; bits 15 to 11 give wake support per state.
// - Never assert wake while in a state whose support bit is zero; wake_assert is registered from the state one cycle earlier.
// - Bit 10 is one only when the D2 state is supported.
// - Bit 9 is one only when the D1 state is supported.
// - Bits 8 to 6 give auxiliary current; 000b when data register exists.
// - Capabilities reset value fixed; bits 13, 11, 10 depend on host type.
// - Version field bits 2 to 0 reads 010b.
// - Bit 3 reads zero: wake needs no bus clock.
// - Bit 5 reads zero: no device-specific initialization needed.
`timescale 1ns/1ns
`default_nettype none
module pci_power_capability_regs #(
    parameter bit ENHANCED_HOST = 1'b0,
    parameter bit DATA_REG_IMPL = 1'b0,
    parameter logic [7:0] CAP_BASE = pci_pm_pkg::CAP_BASE_DEFAULT,
    parameter logic [2:0] AUX_CURRENT = pci_pm_pkg::AUX_DEFAULT
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cfg_req,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    input wire pci_pm_pkg::power_state_t power_state,
    input wire logic wake_request,
    output logic wake_assert
);
    import pci_pm_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    logic [7:0] capability_identifier_q;
    logic [7:0] next_ptr_q;
    logic [15:0] pmc_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Capability fields as fixed by the host type and the build options.
    wire logic [4:0] wake_bits = ENHANCED_HOST ? WAKE_ENH : WAKE_OPEN;
    wire logic [2:0] aux_bits = (DATA_REG_IMPL || !wake_bits[4]) ? AUX_NONE : AUX_CURRENT;
    wire logic [7:0] next_reset = ENHANCED_HOST ? NEXT_PTR_ENH : NEXT_PTR_OPEN;
    logic [15:0] pmc_reset;

    always_comb begin
        pmc_reset = PMC_ZERO;
        pmc_reset[WAKE_LSB +: 5] = wake_bits;
        pmc_reset[D2_BIT] = ENHANCED_HOST;
        pmc_reset[D1_BIT] = 1'b1;
        pmc_reset[AUX_LSB +: 3] = aux_bits;
        pmc_reset[DSI_BIT] = 1'b0;
        pmc_reset[RSVD_BIT] = 1'b0;
        pmc_reset[PMI_BIT] = 1'b0;
        pmc_reset[VER_LSB +: 3] = VER_VALUE;
    end

    // Dword decode: the pointer dword and the first dword of the structure.
    // Byte lanes are ignored: a read always returns the whole dword and the host picks its bytes.
    // Control/status, bridge and data bytes are not built here and read as zero.
    wire logic hit_ptr = cfg_addr[7:2] == CAP_PTR_ADDR[7:2];
    wire logic hit_base = cfg_addr[7:2] == CAP_BASE[7:2];
    wire logic rd_take = cfg_req && !cfg_we;

    // Words offered by the two decoded dwords; byte 0 of the base word is the identifier.
    wire logic [31:0] base_word = {pmc_q, next_ptr_q, capability_identifier_q};
    wire logic [31:0] ptr_word = {24'h00_0000, CAP_BASE};

    // Only the base dword can return the identifier, so the list holds it once.
    assign rdata_d = !rd_take ? rdata_q :
                     hit_base ? base_word :
                     hit_ptr ? ptr_word :
                     WORD_ZERO;

    // The fields load only at reset; a write is acknowledged and dropped.
    // Flops rather than plain constants give the fields a defined reload point, at the cost of
    // reading unknown until the first reset edge.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            capability_identifier_q <= CAPABILITY_IDENTIFIER_VALUE;
            next_ptr_q <= next_reset;
            pmc_q <= pmc_reset;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            rdata_q <= WORD_ZERO;
        end else begin
            // Writes are answered like reads, so the host never waits on a dropped write.
            ack_q <= cfg_req;
            rdata_q <= rdata_d;
        end
    end

    assign cfg_ack = ack_q;
    assign cfg_rdata = rdata_q;

    // The gate reads the wake bits from the stored word, so the word and the line cannot disagree.
    wake_gate u_wake_gate (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .power_state(power_state),
        .wake_support_per_state(pmc_q[WAKE_LSB +: 5]),
        .wake_request(wake_request),
        .wake_assert(wake_assert)
    );

    // Every check below runs on the bus clock and rests while reset is high.
    wire logic base_read = rd_take && hit_base;

    // Samples of the wake inputs for the state-by-state wake checks.
    wire logic open_no_wake = power_state == PS_D0 || power_state == PS_D2;
    wire logic cold_request = wake_request && power_state == PS_D3COLD;

    ack_timing_a: assert property (cfg_req |=> cfg_ack)
        else $error("Request not acknowledged one cycle later.");
    ack_cause_a: assert property (cfg_ack |-> $past(cfg_req))
        else $error("Acknowledge without a request.");
    pointer_read_a: assert property (rd_take && hit_ptr |=> cfg_rdata[7:0] == CAP_BASE)
        else $error("Capability pointer read returned the wrong base.");
    ident_read_a: assert property (base_read |=> cfg_rdata[7:0] == CAPABILITY_IDENTIFIER_VALUE)
        else $error("Identifier byte does not read 01h.");
    ident_unique_a: assert property (rd_take && !hit_base |=> cfg_rdata[7:0] != CAPABILITY_IDENTIFIER_VALUE)
        else $error("Identifier value seen outside the structure base.");
    next_read_a: assert property (base_read |=> cfg_rdata[15:8] == next_reset)
        else $error("Next pointer does not match the host type.");
    wake_field_a: assert property (base_read |=> cfg_rdata[31:27] == wake_bits)
        else $error("Wake support bits are wrong.");
    state_bits_a: assert property (base_read |=>
        cfg_rdata[16 + D2_BIT] == ENHANCED_HOST && cfg_rdata[16 + D1_BIT])
        else $error("D1 or D2 support bit is wrong.");
    aux_field_a: assert property (base_read && DATA_REG_IMPL |=> cfg_rdata[24:22] == AUX_NONE)
        else $error("Auxiliary current not zero with data register present.");
    low_fields_a: assert property (base_read |=>
        cfg_rdata[18:16] == VER_VALUE && !cfg_rdata[16 + PMI_BIT] && !cfg_rdata[16 + DSI_BIT])
        else $error("Version, clock or initialization bit is wrong.");
    write_hold_a: assert property (cfg_req && cfg_we |=> $stable(pmc_q) && $stable(next_ptr_q)
        && $stable(capability_identifier_q) && $stable(cfg_rdata) && cfg_ack)
        else $error("Write changed a read-only field.");

    // Requests and acknowledges line up one for one; the host counts on that to pair answers.
    ack_idle_a: assert property (!cfg_req |=> !cfg_ack)
        else $error("Acknowledge raised without a request one cycle earlier.");

    // Read data stand until the next read, so a write cannot hide the last answer.
    rdata_hold_a: assert property (!rd_take |=> $stable(cfg_rdata))
        else $error("Read data changed without a read.");

    // Every dword but the pointer and the base reads zero, so nothing else looks like a list item.
    unmapped_zero_a: assert property (rd_take && !hit_base && !hit_ptr |=>
        cfg_rdata == WORD_ZERO)
        else $error("Unmapped configuration dword did not read zero.");

    pointer_upper_a: assert property (rd_take && hit_ptr |=> cfg_rdata[31:8] == 24'h00_0000)
        else $error("Pointer dword carries bits above the pointer byte.");

    // A base inside the pointer dword or off a dword boundary would break the list walk.
    base_place_a: assert property (CAP_BASE[1:0] == 2'h0 && CAP_BASE[7:2] != CAP_PTR_ADDR[7:2])
        else $error("Structure base is not a free aligned dword.");

    // The fields are constants once reset has loaded them.
    fields_const_a: assert property (1'b1 |=>
        $stable(capability_identifier_q) && $stable(next_ptr_q) && $stable(pmc_q))
        else $error("A read-only field changed outside reset.");

    ident_reg_a: assert property (capability_identifier_q == CAPABILITY_IDENTIFIER_VALUE)
        else $error("Identifier register does not hold the power-management code.");

    next_reg_a: assert property (next_ptr_q == (ENHANCED_HOST ? NEXT_PTR_ENH : NEXT_PTR_OPEN))
        else $error("Next-pointer register does not match the host type.");

    d1_reg_a: assert property (pmc_q[D1_BIT] && pmc_q[D2_BIT] == ENHANCED_HOST)
        else $error("D1 or D2 support register bit is wrong.");

    version_reg_a: assert property (pmc_q[VER_LSB +: 3] == VER_VALUE)
        else $error("Version field register holds the wrong value.");

    aux_reg_a: assert property (DATA_REG_IMPL |-> pmc_q[AUX_LSB +: 3] == AUX_NONE)
        else $error("Auxiliary current not cleared although the data register exists.");

    // Bits 15, 14 and 12 are set for both host types; bits 13, 11 and 10 follow the host type.
    host_bits_a: assert property (base_read |=> cfg_rdata[31] && cfg_rdata[30] && cfg_rdata[28]
        && cfg_rdata[29] == ENHANCED_HOST && cfg_rdata[27] == ENHANCED_HOST
        && cfg_rdata[26] == ENHANCED_HOST)
        else $error("Host-type bits of the capabilities word are wrong.");

    zero_bits_a: assert property (base_read |=>
        !cfg_rdata[16 + RSVD_BIT] && !cfg_rdata[16] && !cfg_rdata[18])
        else $error("Reserved or fixed-zero bit of the capabilities word is set.");

    last_item_a: assert property (base_read && !ENHANCED_HOST |=> cfg_rdata[15:8] == NEXT_PTR_OPEN)
        else $error("Open host structure is not the last list item.");

    // The wake line is checked here against the states themselves, not against the stored word.
    wake_cause_a: assert property (wake_assert |-> $past(wake_request))
        else $error("Wake asserted without a request.");

    wake_open_a: assert property (!ENHANCED_HOST && $past(open_no_wake) |-> !wake_assert)
        else $error("Open host asserted wake from D0 or D2.");

    wake_cold_a: assert property (!$past(sys_rst) && $past(cold_request) |-> wake_assert)
        else $error("Wake request from D3cold was not passed on.");

    // Cover points for the main scenarios.
    base_read_c: cover property (base_read ##1 cfg_ack);
    write_then_read_c: cover property (cfg_req && cfg_we ##1 base_read);
    pointer_read_c: cover property (rd_take && hit_ptr);
    wake_out_c: cover property (wake_assert);
endmodule
`default_nettype wire

// [bench/cfg_host_model.sv]
// Configuration host model that issues single-cycle register accesses.
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model (
    input wire logic mclk,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    output logic cfg_req,
    output logic cfg_we,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata
);
    initial begin
        cfg_req = 1'b0;
        cfg_we = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end

    // The answer must come one edge after the request and stand for one cycle only.
    task automatic access(input logic we, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic acked);
        @(negedge mclk);
        cfg_req = 1'b1;
        cfg_we = we;
        cfg_addr = addr;
        cfg_be = 4'hf;
        cfg_wdata = wdata;
        @(negedge mclk);
        // Released lines but the byte enables show the inverse so a stale value cannot pass for a live one.
        cfg_req = 1'b0;
        cfg_we = ~we;
        cfg_addr = ~addr;
        cfg_wdata = ~wdata;
        acked = (cfg_ack === 1'b1);
        rdata = cfg_rdata;
        @(negedge mclk);
        acked = acked && (cfg_ack === 1'b0);
    endtask
endmodule
`default_nettype wire

// [bench/pci_power_capability_regs_test.sv]
// Self-checking bench for the power-management capability registers.
`timescale 1ns/1ns
`default_nettype none
module pci_power_capability_regs_test;
    import pci_pm_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic wake_request = 1'b0;
    logic cfg_req, cfg_we, cfg_ack, wake_assert, ok;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, rd;
    logic e_req, e_we, e_ack, wake_enh;
    logic [7:0] e_addr;
    logic [3:0] e_be;
    logic [31:0] e_wdata, e_rdata;
    power_state_t power_state = PS_D0;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    always #20 mclk = ~mclk;

    pci_power_capability_regs DUT (.mclk(mclk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_we(cfg_we),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .power_state(power_state), .wake_request(wake_request),
        .wake_assert(wake_assert));
    cfg_host_model host (.mclk(mclk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));

    // Second build: enhanced host with the data register, so the other host type and the aux override run.
    pci_power_capability_regs #(.ENHANCED_HOST(1'b1), .DATA_REG_IMPL(1'b1)) DUT_ENH (.mclk(mclk),
        .sys_rst(sys_rst), .cfg_req(e_req), .cfg_we(e_we), .cfg_addr(e_addr), .cfg_be(e_be),
        .cfg_wdata(e_wdata), .cfg_ack(e_ack), .cfg_rdata(e_rdata), .power_state(power_state),
        .wake_request(wake_request), .wake_assert(wake_enh));
    cfg_host_model host_enh (.mclk(mclk), .cfg_ack(e_ack), .cfg_rdata(e_rdata), .cfg_req(e_req),
        .cfg_we(e_we), .cfg_addr(e_addr), .cfg_be(e_be), .cfg_wdata(e_wdata));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
        comparisons++;
        if (seen !== expected) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, expected, seen);
        end
    endtask

    task automatic complete_run();
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Open host word: wake from D1, D3hot, D3cold, D1 only, aux 010b, version 010b, id 01h, last item.
    task automatic read_structure();
        host.access(1'b0, CAP_PTR_ADDR, 32'h0, rd, ok);
        check("ptr ack", {31'h0, ok}, 32'h1);
        check("cap pointer", rd, {24'h0, CAP_BASE_DEFAULT});
        host.access(1'b0, rd[7:0], 32'h0, rd, ok);
        check("base ack", {31'h0, ok}, 32'h1);
        check("pm word", rd, 32'hd282_0001);
        check("pm fields", {rd[31:16], 16'h0}, 32'hd282_0000);
    endtask

    // Enhanced host with data register: wake from all states, D1 and D2, no aux current, next item e4h.
    task automatic read_enhanced();
        host_enh.access(1'b0, CAP_PTR_ADDR, 32'h0, rd, ok);
        check("enh cap pointer", rd, {24'h0, CAP_BASE_DEFAULT});
        host_enh.access(1'b0, rd[7:0], 32'h0, rd, ok);
        check("enh base ack", {31'h0, ok}, 32'h1);
        check("enh pm word", rd, 32'hfe02_e401);
    endtask

    // A reset in mid-run must clear the bus outputs and the wake line, then reload the fields.
    task automatic reset_midrun();
        host.access(1'b0, CAP_BASE_DEFAULT, 32'h0, rd, ok);
        @(negedge mclk);
        sys_rst = 1'b1;
        wake_request = 1'b1;
        repeat (2) @(negedge mclk);
        check("reset ack", {31'h0, cfg_ack}, 32'h0);
        check("reset rdata", cfg_rdata, 32'h0);
        check("reset wake", {31'h0, wake_assert}, 32'h0);
        sys_rst = 1'b0;
        wake_request = 1'b0;
        host.access(1'b0, CAP_BASE_DEFAULT, 32'h0, rd, ok);
        check("reload word", rd, 32'hd282_0001);
    endtask

    task automatic write_ignored();
        host.access(1'b1, CAP_BASE_DEFAULT, 32'hffff_ffff, rd, ok);
        check("write ack", {31'h0, ok}, 32'h1);
        check("write rdata", rd, 32'hd282_0001);
        host.access(1'b0, CAP_BASE_DEFAULT, 32'h0, rd, ok);
        check("after write", rd, 32'hd282_0001);
        host.access(1'b0, CAP_BASE_DEFAULT + OFS_CTRL, 32'h0, rd, ok);
        check("ctrl dword", rd, 32'h0);
    endtask

    task automatic wake_states();
        logic [4:0] support;
        support = 5'h1a;
        for (int i = 0; i < 5; i++) begin
            @(negedge mclk);
            power_state = power_state_t'(5'h01 << i);
            wake_request = 1'b1;
            @(negedge mclk);
            check("wake", {31'h0, wake_assert}, {31'h0, support[i]});
            check("wake enh", {31'h0, wake_enh}, 32'h1);
            wake_request = 1'b0;
            @(negedge mclk);
            check("wake idle", {31'h0, wake_assert}, 32'h0);
            check("wake enh idle", {31'h0, wake_enh}, 32'h0);
        end
    endtask

    initial begin
        repeat (8) @(negedge mclk);
        sys_rst = 1'b0;
        read_structure();
        read_enhanced();
        write_ignored();
        wake_states();
        reset_midrun();
        complete_run();
    end

    // The sequence needs well under a hundred cycles; the ceiling only catches a hang.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            complete_run();
        end
    end
endmodule
`default_nettype wire
